// >>> rtl/can_acceptance_filter.sv
/*
  CAN acceptance filtering plus send and receive sequencing.
  Assumes a link engine outside that sends frames and reports received
  ones, and a host that reaches mask, filter and frame ports directly.
*/
module can_acceptance_filter
  import can_filter_pkg::*;
(
  input  wire logic                 clock,          // 100 MHz clock
  input  wire logic                 sys_rst,        // Async reset, high
  // Mask access
  input  wire logic                 mask_wr,        // Write selected mask
  input  wire logic                 mask_selector,  // 0 first, 1 second
  input  wire logic [ID_W-1:0]      mask_wdata,     // Mask pattern in
  output logic      [ID_W-1:0]      mask_rdata,     // Selected mask out
  // Filter access
  input  wire logic                 filter_wr,      // Write selected filter
  input  wire logic [SEL_W-1:0]     filter_selector, // Filter 0..5
  input  wire id_kind_e             filter_id_kind, // Kind on write
  input  wire logic [ID_W-1:0]      filter_wdata,   // Filter pattern in
  output logic      [ID_W-1:0]      filter_rdata,   // Selected filter out
  output id_kind_e                  filter_rkind,   // Selected filter kind
  output logic                      filter_err,     // Last write bad index
  // Mode
  input  wire logic                 full_mode,      // Accept every frame
  // Transmit batch from host
  input  wire logic                 tx_start,       // Begin a batch
  input  wire logic [CNT_W-1:0]     tx_count,       // Frames in batch
  input  wire logic                 tx_in_valid,    // Next frame offered
  output logic                      tx_in_ready,    // Frame taken
  input  wire logic [ID_W-1:0]      tx_in_id,       // Frame identifier
  input  wire id_kind_e             tx_in_kind,     // Frame id kind
  input  wire logic [LEN_W-1:0]     tx_in_len,      // Valid byte count
  input  wire logic [DATA_W-1:0]    tx_in_data,     // Payload bytes
  // Transmit to link engine
  output logic                      tx_valid,       // Frame for link
  input  wire logic                 tx_ready,       // Link took frame
  input  wire logic                 tx_fail,        // Link send failed
  output logic      [ID_W-1:0]      tx_id,          // Link frame id
  output id_kind_e                  tx_kind,        // Link frame kind
  output logic      [LEN_W-1:0]     tx_len,         // Link frame length
  output logic      [DATA_W-1:0]    tx_data,        // Link frame payload
  output logic                      tx_busy,        // Batch in progress
  output logic                      tx_done,        // Batch end pulse
  output logic                      tx_ok,          // Last batch all sent
  // Receive from link engine
  input  wire logic                 rx_valid,       // Frame received
  input  wire logic [ID_W-1:0]      rx_id,          // Received id
  input  wire id_kind_e             rx_kind,        // Received id kind
  input  wire logic [LEN_W-1:0]     rx_len,         // Received length
  input  wire logic [DATA_W-1:0]    rx_data,        // Received payload
  // Receive delivery to host
  input  wire logic                 rx_start,       // Begin a request
  input  wire logic [CNT_W-1:0]     rx_count,       // Frames wanted
  output logic                      out_valid,      // Accepted frame out
  output logic      [CNT_W-1:0]     out_slot,       // Slot of this frame
  output logic      [ID_W-1:0]      out_id,         // Accepted id
  output id_kind_e                  out_kind,       // Accepted kind
  output logic      [LEN_W-1:0]     out_len,        // Accepted length
  output logic      [DATA_W-1:0]    out_data,       // Accepted payload
  output logic                      rx_busy,        // Request in progress
  output logic                      rx_done         // Request end pulse
);

  // ------------------------------------------------------------
  // Mask and filter storage
  // ------------------------------------------------------------
  logic [ID_W-1:0] mask_ff     [NUM_MASKS];
  logic [ID_W-1:0] nxt_mask    [NUM_MASKS];
  logic [ID_W-1:0] filter_ff   [NUM_FILTERS];
  logic [ID_W-1:0] nxt_filter  [NUM_FILTERS];
  id_kind_e        kind_ff     [NUM_FILTERS];
  id_kind_e        nxt_kind    [NUM_FILTERS];
  logic            ferr_ff;
  logic            nxt_ferr;
  logic            bad_sel;
  logic [NUM_FILTERS-1:0] hit;

  assign bad_sel = filter_selector > LAST_FILTER;

  always_comb begin
    nxt_mask   = mask_ff;
    nxt_filter = filter_ff;
    nxt_kind   = kind_ff;
    nxt_ferr   = ferr_ff;
    if (mask_wr) begin
      nxt_mask[mask_selector] = mask_wdata;
    end
    if (filter_wr) begin
      nxt_ferr = bad_sel;
      if (!bad_sel) begin
        nxt_kind[filter_selector] = filter_id_kind;
        // Clip value to the width its kind allows
        nxt_filter[filter_selector] =
          (filter_id_kind == short_identifier_kind) ?
          (filter_wdata & SHORT_ID_MASK) :
          (filter_wdata & LONG_ID_MASK);
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        mask_ff[i] <= MASK_RST;
      end
      for (int i = 0; i < NUM_FILTERS; i++) begin
        filter_ff[i] <= FILTER_RST;
        kind_ff[i]   <= short_identifier_kind;
      end
      ferr_ff <= 1'b0;
    end else begin
      mask_ff   <= nxt_mask;
      filter_ff <= nxt_filter;
      kind_ff   <= nxt_kind;
      ferr_ff   <= nxt_ferr;
    end
  end

  assign mask_rdata   = mask_ff[mask_selector];
  assign filter_rdata = bad_sel ? '0 : filter_ff[filter_selector];
  assign filter_rkind = bad_sel ? short_identifier_kind
                                : kind_ff[filter_selector];
  assign filter_err   = ferr_ff;

  // ------------------------------------------------------------
  // Acceptance
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++) begin : g_match
      id_match u_match (
        .mask_bits   (mask_ff[(g < FIRST_MASK_LIMIT) ? 0 : 1]),
        .filter_bits (filter_ff[g]),
        .filter_kind (kind_ff[g]),
        .rx_id       (rx_id),
        .rx_kind     (rx_kind),
        .hit         (hit[g])
      );
    end
  endgenerate

  logic accept;
  // Full mode is a plain port; the system holds it low out of reset
  assign accept = rx_valid && (full_mode || (|hit));

  // ------------------------------------------------------------
  // Receive sequencing
  // ------------------------------------------------------------
  logic [CNT_W-1:0] rx_left_ff, nxt_rx_left;
  logic [CNT_W-1:0] slot_ff, nxt_slot;
  logic             oval_ff, nxt_oval;
  logic             rdone_ff, nxt_rdone;
  logic [ID_W-1:0]  oid_ff, nxt_oid;
  id_kind_e         okind_ff, nxt_okind;
  logic [LEN_W-1:0] olen_ff, nxt_olen;
  logic [DATA_W-1:0] odata_ff, nxt_odata;

  always_comb begin
    nxt_rx_left = rx_left_ff;
    nxt_slot    = slot_ff;
    nxt_oval    = 1'b0;
    nxt_rdone   = 1'b0;
    nxt_oid     = oid_ff;
    nxt_okind   = okind_ff;
    nxt_olen    = olen_ff;
    nxt_odata   = odata_ff;
    if (rx_start && rx_left_ff == CNT_ZERO) begin
      nxt_rx_left = rx_count;
      nxt_slot    = CNT_ZERO;
      nxt_rdone   = (rx_count == CNT_ZERO);
    end else if (rx_left_ff != CNT_ZERO && accept) begin
      // Frames outside a request are dropped; no buffering here
      nxt_oval    = 1'b1;
      nxt_oid     = (rx_kind == short_identifier_kind) ?
                    (rx_id & SHORT_ID_MASK) : (rx_id & LONG_ID_MASK);
      nxt_okind   = rx_kind;
      nxt_olen    = (rx_len > MAX_LEN) ? MAX_LEN : rx_len;
      nxt_odata   = rx_data;
      nxt_slot    = slot_ff + CNT_ONE;
      nxt_rx_left = rx_left_ff - CNT_ONE;
      nxt_rdone   = (rx_left_ff == CNT_ONE);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_left_ff <= CNT_ZERO;
      slot_ff    <= CNT_ZERO;
      oval_ff    <= 1'b0;
      rdone_ff   <= 1'b0;
      oid_ff     <= '0;
      okind_ff   <= short_identifier_kind;
      olen_ff    <= '0;
      odata_ff   <= '0;
    end else begin
      rx_left_ff <= nxt_rx_left;
      slot_ff    <= nxt_slot;
      oval_ff    <= nxt_oval;
      rdone_ff   <= nxt_rdone;
      oid_ff     <= nxt_oid;
      okind_ff   <= nxt_okind;
      olen_ff    <= nxt_olen;
      odata_ff   <= nxt_odata;
    end
  end

  assign out_valid = oval_ff;
  assign out_slot  = slot_ff - CNT_ONE;
  assign out_id    = oid_ff;
  assign out_kind  = okind_ff;
  assign out_len   = olen_ff;
  assign out_data  = odata_ff;
  assign rx_busy   = rx_left_ff != CNT_ZERO;
  assign rx_done   = rdone_ff;

  // ------------------------------------------------------------
  // Transmit sequencing
  // ------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} tx_state_e;
  tx_state_e        tx_st_ff, nxt_tx_st;
  logic [CNT_W-1:0] tx_left_ff, nxt_tx_left;
  logic             tx_okf_ff, nxt_tx_okf;
  logic             tdone_ff, nxt_tdone;
  logic [ID_W-1:0]  tid_ff, nxt_tid;
  id_kind_e         tkind_ff, nxt_tkind;
  logic [LEN_W-1:0] tlen_ff, nxt_tlen;
  logic [DATA_W-1:0] tdata_ff, nxt_tdata;

  always_comb begin
    nxt_tx_st   = tx_st_ff;
    nxt_tx_left = tx_left_ff;
    nxt_tx_okf  = tx_okf_ff;
    nxt_tdone   = 1'b0;
    nxt_tid     = tid_ff;
    nxt_tkind   = tkind_ff;
    nxt_tlen    = tlen_ff;
    nxt_tdata   = tdata_ff;
    case (tx_st_ff)
      TX_IDLE: begin
        if (tx_start) begin
          nxt_tx_left = tx_count;
          nxt_tx_okf  = 1'b1;
          if (tx_count == CNT_ZERO) begin
            nxt_tdone = 1'b1;
          end else begin
            nxt_tx_st = TX_LOAD;
          end
        end
      end
      TX_LOAD: begin
        if (tx_in_valid) begin
          nxt_tid   = (tx_in_kind == short_identifier_kind) ?
                      (tx_in_id & SHORT_ID_MASK) :
                      (tx_in_id & LONG_ID_MASK);
          nxt_tkind = tx_in_kind;
          nxt_tlen  = (tx_in_len > MAX_LEN) ? MAX_LEN : tx_in_len;
          nxt_tdata = tx_in_data;
          nxt_tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_ready || tx_fail) begin
          // One failure spoils the batch result; sending goes on
          nxt_tx_okf  = tx_okf_ff && !tx_fail;
          nxt_tx_left = tx_left_ff - CNT_ONE;
          if (tx_left_ff == CNT_ONE) begin
            nxt_tdone = 1'b1;
            nxt_tx_st = TX_IDLE;
          end else begin
            nxt_tx_st = TX_LOAD;
          end
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_ff   <= TX_IDLE;
      tx_left_ff <= CNT_ZERO;
      tx_okf_ff  <= 1'b0;
      tdone_ff   <= 1'b0;
      tid_ff     <= '0;
      tkind_ff   <= short_identifier_kind;
      tlen_ff    <= '0;
      tdata_ff   <= '0;
    end else begin
      tx_st_ff   <= nxt_tx_st;
      tx_left_ff <= nxt_tx_left;
      tx_okf_ff  <= nxt_tx_okf;
      tdone_ff   <= nxt_tdone;
      tid_ff     <= nxt_tid;
      tkind_ff   <= nxt_tkind;
      tlen_ff    <= nxt_tlen;
      tdata_ff   <= nxt_tdata;
    end
  end

  assign tx_in_ready = tx_st_ff == TX_LOAD;
  assign tx_valid    = tx_st_ff == TX_SEND;
  assign tx_id       = tid_ff;
  assign tx_kind     = tkind_ff;
  assign tx_len      = tlen_ff;
  assign tx_data     = tdata_ff;
  assign tx_busy     = tx_st_ff != TX_IDLE;
  assign tx_done     = tdone_ff;
  assign tx_ok       = tx_okf_ff;

endmodule : can_acceptance_filter

// >>> rtl/can_filter_pkg.sv
/*
  Shared constants and types for the CAN acceptance filter block.
  Assumes a single 100 MHz clock and an asynchronous active-high reset.
*/
package can_filter_pkg;

  localparam int unsigned NUM_MASKS   = 2;
  localparam int unsigned NUM_FILTERS = 6;
  localparam int unsigned ID_W        = 32;
  localparam int unsigned SEL_W       = 3;
  localparam int unsigned LEN_W       = 4;
  localparam int unsigned DATA_W      = 64;
  localparam int unsigned CNT_W       = 8;

  // Filters with index below this use the first mask
  localparam logic [SEL_W-1:0] FIRST_MASK_LIMIT = 3'h2;
  localparam logic [SEL_W-1:0] LAST_FILTER      = 3'h5;

  // Short identifiers sit in mask bits 18..28
  localparam int unsigned SHORT_ID_BITS = 11;
  localparam int unsigned SHORT_MASK_LO = 18;
  localparam logic [ID_W-1:0] SHORT_ID_MASK  = 32'h0000_07FF;
  localparam logic [ID_W-1:0] LONG_ID_MASK   = 32'h1FFF_FFFF;
  localparam logic [ID_W-1:0] MASK_RST       = 32'h0000_0000;
  localparam logic [ID_W-1:0] FILTER_RST     = 32'h0000_0000;
  localparam logic [LEN_W-1:0] MAX_LEN       = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ZERO      = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE       = 8'h01;

  typedef enum logic {
    short_identifier_kind,
    long_identifier_kind
  } id_kind_e;

endpackage : can_filter_pkg

// >>> rtl/id_match.sv
/*
  One filter/mask comparison for a received identifier.
  Assumes the caller has already picked the mask that pairs with this filter.
*/
module id_match
  import can_filter_pkg::*;
(
  input  wire logic [ID_W-1:0] mask_bits,    // Selected mask pattern
  input  wire logic [ID_W-1:0] filter_bits,  // Filter pattern
  input  wire id_kind_e        filter_kind,  // Filter identifier kind
  input  wire logic [ID_W-1:0] rx_id,        // Received identifier
  input  wire id_kind_e        rx_kind,      // Received identifier kind
  output logic                 hit           // All checked bits pass
);
  logic [ID_W-1:0] eff_mask;
  logic [ID_W-1:0] id_cmp;
  logic [ID_W-1:0] flt_cmp;

  always_comb begin
    if (filter_kind == short_identifier_kind) begin
      // Mask bits 18..28 steer the 11 identifier bits
      eff_mask = (mask_bits >> SHORT_MASK_LO) & SHORT_ID_MASK;
      id_cmp   = rx_id & SHORT_ID_MASK;
      flt_cmp  = filter_bits & SHORT_ID_MASK;
    end else begin
      eff_mask = mask_bits & LONG_ID_MASK;
      id_cmp   = rx_id & LONG_ID_MASK;
      flt_cmp  = filter_bits & LONG_ID_MASK;
    end
    // Mask 0 passes a bit, mask 1 demands equality
    hit = (rx_kind == filter_kind) &&
          (((id_cmp ^ flt_cmp) & eff_mask) == '0);
  end
endmodule : id_match

// >>> sim/can_acceptance_filter_chk.sv
/* Port checker for can_acceptance_filter.
   Assumes the bind below reaches every instance of the block. */
module can_acceptance_filter_chk (
  input wire logic                            clock,           // Clock
  input wire logic                            sys_rst,         // Reset
  input wire logic                            filter_wr,       // Filter write
  input wire logic [can_filter_pkg::SEL_W-1:0] filter_selector, // Index
  input wire logic                            filter_err,      // Bad index
  input wire logic                            full_mode,       // Accept all
  input wire logic                            tx_valid,        // Link frame
  input wire logic                            tx_ready,        // Link took
  input wire logic                            tx_fail,         // Link failed
  input wire logic [can_filter_pkg::ID_W-1:0]  tx_id,           // Link id
  input wire logic                            tx_busy,         // Batch on
  input wire logic                            tx_done,         // Batch end
  input wire logic                            tx_ok,           // All sent
  input wire logic                            rx_valid,        // Frame in
  input wire logic                            rx_busy,         // Request on
  input wire logic                            out_valid,       // Frame out
  input wire logic [can_filter_pkg::CNT_W-1:0] out_slot,        // Slot
  input wire logic                            rx_done          // Request end
);
  timeunit 1ns;
  timeprecision 1ps;
  import can_filter_pkg::*;
  // ----------------------------
  // Slot tracking and properties
  // ----------------------------
  logic [CNT_W-1:0] exp_slot_ff, nxt_exp_slot;
  always_comb begin
    nxt_exp_slot = exp_slot_ff;
    if (rx_done) nxt_exp_slot = CNT_ZERO;
    else if (out_valid) nxt_exp_slot = out_slot + CNT_ONE;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) exp_slot_ff <= CNT_ZERO;
    else exp_slot_ff <= nxt_exp_slot;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_err_set: assert property (
    filter_wr && filter_selector > LAST_FILTER |=> filter_err)
    else $error("bad filter index not flagged");
  a_err_clear: assert property (
    filter_wr && filter_selector <= LAST_FILTER |=> !filter_err)
    else $error("filter error kept after good write");
  a_tx_hold: assert property (
    tx_valid && !tx_ready && !tx_fail |=> tx_valid && $stable(tx_id))
    else $error("link frame dropped or changed early");
  a_done_pulse: assert property (tx_done |=> !tx_done)
    else $error("batch end longer than one cycle");
  a_done_idle: assert property (tx_done |-> !tx_busy)
    else $error("batch end while busy");
  a_full_accept: assert property (
    rx_valid && rx_busy && full_mode |=> out_valid)
    else $error("full mode frame not delivered");
  a_out_cause: assert property (
    out_valid |-> $past(rx_valid) && $past(rx_busy))
    else $error("delivery without received frame");
  a_slot_order: assert property (
    out_valid |-> out_slot == exp_slot_ff)
    else $error("slot out of sequence");
  c_tx_ok: cover property (tx_done && tx_ok);
  c_tx_bad: cover property (tx_done && !tx_ok);
  c_rx_end: cover property (out_valid && rx_done);
endmodule : can_acceptance_filter_chk

bind can_acceptance_filter can_acceptance_filter_chk chk_inst (.clock,
  .sys_rst, .filter_wr, .filter_selector, .filter_err, .full_mode, .tx_valid,
  .tx_ready, .tx_fail, .tx_id, .tx_busy, .tx_done, .tx_ok, .rx_valid,
  .rx_busy, .out_valid, .out_slot, .rx_done);

// >>> sim/can_link_model.sv
/* Behavioural model of the other bus nodes behind the link engine.
   Assumes the bench calls send and sets delay and fail_id while idle. */
module can_link_model (
  input  wire logic                             clock,    // Clock
  input  wire logic                             sys_rst,  // Reset
  input  wire logic                             tx_valid, // Frame offered
  input  wire logic [can_filter_pkg::ID_W-1:0]   tx_id,    // Frame id
  input  wire logic [3:0]                       delay,    // Answer wait
  input  wire logic [can_filter_pkg::ID_W-1:0]   fail_id,  // Id to fail
  output logic                                  tx_ready, // Sent
  output logic                                  tx_fail,  // Not sent
  output logic                                  rx_valid, // Frame in
  output logic      [can_filter_pkg::ID_W-1:0]   rx_id,    // Id in
  output can_filter_pkg::id_kind_e              rx_kind,  // Kind in
  output logic      [can_filter_pkg::LEN_W-1:0]  rx_len,   // Length in
  output logic      [can_filter_pkg::DATA_W-1:0] rx_data   // Payload in
);
  timeunit 1ns;
  timeprecision 1ps;
  import can_filter_pkg::*;
  // -------------------------
  // Transmit answer, receive
  // -------------------------
  logic [3:0] wait_cnt;
  initial rx_valid = 1'b0;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {wait_cnt, tx_ready, tx_fail} <= '0;
    end else begin
      {tx_ready, tx_fail} <= 2'h0;
      if (tx_valid && !tx_ready && !tx_fail) begin
        wait_cnt <= (wait_cnt == delay) ? 4'h0 : wait_cnt + 4'h1;
        if (wait_cnt == delay && tx_id == fail_id) tx_fail <= 1'b1;
        else if (wait_cnt == delay) tx_ready <= 1'b1;
      end
    end
  end
  task automatic send(input logic [ID_W-1:0] id, input id_kind_e k,
                      input logic [LEN_W-1:0] n, input logic [DATA_W-1:0] d);
    @(posedge clock);
    #1 {rx_valid, rx_id, rx_len, rx_data} = {1'b1, id, n, d};
    rx_kind = k;
    @(posedge clock);
    // Lines no longer hold the frame once the pulse ends
    #1 {rx_valid, rx_id, rx_len, rx_data} = {1'b0, ~id, ~n, ~d};
  endtask : send
endmodule : can_link_model

// >>> sim/can_acceptance_filter_tb.sv
/* Self-checking bench for can_acceptance_filter and the link model.
   Assumes 100 MHz clock, async active-high reset held six cycles. */
module can_acceptance_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import can_filter_pkg::*;
  // ------------------------
  // Signals, tasks, sequence
  // ------------------------
  logic clock = 1'b0, sys_rst = 1'b1;
  logic mask_wr, mask_selector, filter_wr, filter_err, full_mode;
  logic tx_start, tx_in_valid, tx_in_ready, tx_valid, tx_ready, tx_fail;
  logic tx_busy, tx_done, tx_ok, rx_valid, rx_start, out_valid, rx_busy;
  logic rx_done;
  logic [ID_W-1:0] mask_wdata, mask_rdata, filter_wdata, filter_rdata;
  logic [ID_W-1:0] tx_in_id, tx_id, rx_id, out_id, fail_id;
  logic [SEL_W-1:0] filter_selector;
  logic [CNT_W-1:0] tx_count, rx_count, out_slot;
  logic [LEN_W-1:0] tx_in_len, rx_len, out_len, tx_len;
  logic [DATA_W-1:0] tx_in_data, rx_data, out_data, tx_data;
  logic [3:0] delay;
  id_kind_e filter_id_kind, filter_rkind, tx_in_kind, rx_kind;
  id_kind_e out_kind, tx_kind;
  int n_errors = 0, n_tests = 0;
  logic [43:0] oq[$];
  logic [ID_W-1:0] tq[$];
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (out_valid) oq.push_back({out_slot, out_id, out_len});
    if (tx_valid && (tx_ready || tx_fail)) tq.push_back(tx_id);
  end
  can_acceptance_filter can_acceptance_filter_inst (.clock, .sys_rst,
    .mask_wr, .mask_selector, .mask_wdata, .mask_rdata, .filter_wr,
    .filter_selector, .filter_id_kind, .filter_wdata, .filter_rdata,
    .filter_rkind, .filter_err, .full_mode, .tx_start, .tx_count,
    .tx_in_valid, .tx_in_ready, .tx_in_id, .tx_in_kind, .tx_in_len,
    .tx_in_data, .tx_valid, .tx_ready, .tx_fail, .tx_id, .tx_kind,
    .tx_len, .tx_data, .tx_busy, .tx_done, .tx_ok, .rx_valid, .rx_id,
    .rx_kind, .rx_len, .rx_data, .rx_start, .rx_count, .out_valid,
    .out_slot, .out_id, .out_kind, .out_len, .out_data, .rx_busy,
    .rx_done);
  can_link_model can_link_model_inst (.clock, .sys_rst, .tx_valid, .tx_id,
    .delay, .fail_id, .tx_ready, .tx_fail, .rx_valid, .rx_id, .rx_kind,
    .rx_len, .rx_data);
  task automatic chk(input string what, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr_mask(input logic s, input logic [ID_W-1:0] v);
    {mask_wr, mask_selector, mask_wdata} = {1'b1, s, v};
    tick();
    mask_wr = 1'b0;
    tick();
  endtask : wr_mask
  task automatic wr_filt(input logic [2:0] s, input id_kind_e k,
                         input logic [ID_W-1:0] v);
    {filter_wr, filter_selector, filter_wdata} = {1'b1, s, v};
    filter_id_kind = k;
    tick();
    filter_wr = 1'b0;
    tick();
  endtask : wr_filt
  task automatic snd(input logic [ID_W-1:0] id, input id_kind_e k,
                     input logic [3:0] n);
    can_link_model_inst.send(id, k, n, {2{id}});
  endtask : snd
  task automatic rx_req(input logic [7:0] n);
    oq.delete();
    {rx_start, rx_count} = {1'b1, n};
    tick();
    rx_start = 1'b0;
  endtask : rx_req
  task automatic wait_rx();
    while (rx_busy) tick();
    tick();
  endtask : wait_rx
  task automatic t_regs();
    chk("mask_rst", mask_rdata, MASK_RST);
    chk("tx_ok_rst", tx_ok, 1'b0);
    wr_mask(1'b1, 32'h1FFF_FFFF);
    wr_mask(1'b0, 32'h1FF8_FFFF);
    chk("first_mask", mask_rdata, 32'h1FF8_FFFF);
    mask_selector = 1'b1;
    tick();
    chk("second_mask", mask_rdata, 32'h1FFF_FFFF);
    wr_filt(3'h5, long_identifier_kind, 32'hFFFF_FFFF);
    chk("filt5", filter_rdata, LONG_ID_MASK);
    chk("filt5_kind", filter_rkind, long_identifier_kind);
    wr_filt(3'h6, long_identifier_kind, 32'h0000_0001);
    chk("bad_index", filter_err, 1'b1);
    chk("bad_read", filter_rdata, 32'h0);
    wr_filt(3'h0, short_identifier_kind, 32'hFFFF_F123);
    chk("filt0", filter_rdata, 32'h0000_0123);
    chk("err_clear", filter_err, 1'b0);
    wr_filt(3'h5, long_identifier_kind, 32'h1ABC_DEF0);
  endtask : t_regs
  task automatic t_rx();
    rx_req(8'h03);
    snd(32'h0000_0122, short_identifier_kind, 4'h2);
    snd(32'h0000_0124, short_identifier_kind, 4'h1);
    snd(32'h1ABC_DEF0, long_identifier_kind, 4'h8);
    snd(32'h1ABC_DEF1, long_identifier_kind, 4'h8);
    snd(32'hFFFF_F923, short_identifier_kind, 4'h9);
    wait_rx();
    chk("rx_n", oq.size(), 3);
    chk("rx0", oq[0], {8'h00, 32'h0000_0122, 4'h2});
    chk("rx1", oq[1], {8'h01, 32'h1ABC_DEF0, 4'h8});
    chk("rx2", oq[2], {8'h02, 32'h0000_0123, 4'h8});
    chk("rx2_kind", out_kind, short_identifier_kind);
    chk("rx2_data", out_data, {2{32'hFFFF_F923}});
  endtask : t_rx
  task automatic t_full();
    full_mode = 1'b1;
    rx_req(8'h02);
    snd(32'h0000_0456, short_identifier_kind, 4'h0);
    snd(32'h0ABC_DEF0, long_identifier_kind, 4'h1);
    wait_rx();
    chk("full0", oq[0], {8'h00, 32'h0000_0456, 4'h0});
    chk("full1", oq[1], {8'h01, 32'h0ABC_DEF0, 4'h1});
    chk("full1_kind", out_kind, long_identifier_kind);
    chk("full1_data", out_data, {2{32'h0ABC_DEF0}});
    full_mode = 1'b0;
    rx_req(8'h01);
    snd(32'h0000_0456, short_identifier_kind, 4'h0);
    snd(32'h0000_0123, short_identifier_kind, 4'h3);
    wait_rx();
    chk("normal", oq[0], {8'h00, 32'h0000_0123, 4'h3});
    rx_req(8'h00);
    chk("rx_zero", rx_done, 1'b1);
  endtask : t_full
  task automatic tx_batch(input int n, input logic [3:0] dly,
                          input logic [ID_W-1:0] fid, input logic ok);
    {delay, fail_id} = {dly, fid};
    tq.delete();
    {tx_start, tx_count} = {1'b1, n[7:0]};
    tick();
    tx_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      {tx_in_valid, tx_in_id, tx_in_len} = {1'b1, 32'h11 * (i + 1), 4'h9};
      tx_in_data = {2{32'h11 * (i + 1)}};
      while (!tx_in_ready) tick();
      tick();
    end
    tx_in_valid = 1'b0;
    while (!tx_done) tick();
    chk("tx_ok", tx_ok, ok);
    chk("tx_n", tq.size(), n);
    foreach (tq[i]) chk("tx_id", tq[i], 32'h11 * (i + 1));
    if (n > 0) begin
      chk("tx_len", tx_len, 4'h8);
      chk("tx_kind", tx_kind, long_identifier_kind);
      chk("tx_data", tx_data, {2{32'h11 * n}});
    end
  endtask : tx_batch
  initial begin
    {mask_wr, filter_wr, full_mode, tx_start, tx_in_valid, rx_start} = '0;
    {mask_selector, mask_wdata, filter_selector, filter_wdata} = '0;
    {tx_count, rx_count, tx_in_id, tx_in_len, tx_in_data} = '0;
    {delay, fail_id} = '0;
    filter_id_kind = short_identifier_kind;
    tx_in_kind = long_identifier_kind;
    tick(6);
    sys_rst = 1'b0;
    t_regs();
    t_rx();
    t_full();
    tx_batch(3, 4'h2, 32'h0, 1'b1);
    tx_batch(3, 4'h0, 32'h22, 1'b0);
    tx_batch(0, 4'h0, 32'h0, 1'b1);
    end_sim();
  end
  // Tests need about 70 cycles; limit leaves wide margin
  initial begin
    #20us;
    n_errors++;
    end_sim();
  end
endmodule : can_acceptance_filter_tb
